// ---- src/frs_rww_ctl.sv ----
// top of the program memory section control: avalon slave, registers, irq
// assumes core, flash macro and bus master all run on clk_sys
`default_nettype none
module frs_rww_ctl (
  // clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       reset,
  // avalon-mm slave
  input  wire logic [4:0]                 avs_address,
  input  wire logic                       avs_read,
  input  wire logic                       avs_write,
  input  wire logic [31:0]                avs_writedata,
  output logic      [31:0]                avs_readdata,
  output logic                            avs_waitrequest,
  // core side
  input  wire logic [frs_pkg::PC_W-1:0]   core_pc,
  input  wire logic [1:0]                 boot_size_fuses,
  output logic      [frs_pkg::PC_W-1:0]   vector_base,
  output logic                            irq_block,
  output logic                            cpu_halt,
  output logic                            concurrent_blocked,
  // flash macro
  input  wire logic                       flash_done,
  output logic                            flash_req,
  output logic                            flash_erase,
  output logic      [frs_pkg::PAGE_W-1:0] flash_page,
  // interrupt
  output logic                            irq
);
  typedef struct packed {
    logic                              wait_n;
    logic [31:0]                       rdata;
    logic                              start;
    logic                              erase;
    logic [frs_pkg::PAGE_W-1:0]        page;
    logic [frs_pkg::PC_W-1:0]          pc;
    logic [1:0]                        lock;
    logic                              clr_blk;
    logic [frs_pkg::EV_N-1:0]          stat;
    logic [frs_pkg::EV_N-1:0]          en;
    logic                              irq;
    logic [frs_pkg::PC_W-1:0]          vbase;
    logic                              halt;
    logic                              blocked;
  } frs_top_t;
  frs_top_t s_ff, nxt_s;

  frs_seq_if sq ();
  logic unlock;
  logic vsel;
  logic vblk;
  logic take;
  logic wr_cc;
  logic [frs_pkg::EV_N-1:0] ev;
  logic [31:0] rd;

  // a request is taken at the edge where waitrequest is low
  assign take  = (avs_read || avs_write) && s_ff.wait_n;
  assign wr_cc = take && avs_write && avs_address == frs_pkg::OFS_CORE_CTL;

  frs_vec_unlock frs_vec_unlock_i (
    .clk_sys              (clk_sys),
    .reset                (reset),
    .wr                   (wr_cc),
    .d_unlock             (avs_writedata[frs_pkg::CC_UNLOCK]),
    .d_select             (avs_writedata[frs_pkg::CC_SELECT]),
    .vector_change_unlock (unlock),
    .vector_table_select  (vsel),
    .irq_block            (vblk)
  );

  frs_prog_seq frs_prog_seq_i (
    .clk_sys     (clk_sys),
    .reset       (reset),
    .sq          (sq.seq),
    .flash_done  (flash_done),
    .flash_req   (flash_req),
    .flash_erase (flash_erase),
    .flash_page  (flash_page)
  );

  // request fields to the sequencer
  assign sq.start   = s_ff.start;
  assign sq.erase   = s_ff.erase;
  assign sq.page    = s_ff.page;
  assign sq.pc      = s_ff.pc;
  assign sq.lock    = s_ff.lock;
  assign sq.fuse    = boot_size_fuses;
  assign sq.clr_blk = s_ff.clr_blk;

  // event vector for the sticky status
  always_comb begin
    ev = '0;
    ev[frs_pkg::EV_DONE]    = sq.done_ev;
    ev[frs_pkg::EV_REFUSED] = sq.ref_ev;
  end

  // read mux; unmapped and write-only offsets read zero
  always_comb begin
    rd = frs_pkg::RD_ZERO;
    unique case (avs_address)
      frs_pkg::OFS_CORE_CTL: begin
        rd[frs_pkg::CC_UNLOCK] = unlock;
        rd[frs_pkg::CC_SELECT] = vsel;
      end
      frs_pkg::OFS_PROG_CSR: begin
        rd[frs_pkg::PC_ERASE]   = s_ff.erase;
        rd[frs_pkg::PC_BLOCKED] = sq.blocked;
        rd[frs_pkg::PC_BUSY]    = sq.busy;
      end
      frs_pkg::OFS_PAGE: rd[frs_pkg::PAGE_W-1:0] = s_ff.page;
      frs_pkg::OFS_LOCK: begin
        rd[frs_pkg::LK_APP]                 = s_ff.lock[frs_pkg::LK_APP];
        rd[frs_pkg::LK_BOOT]                = s_ff.lock[frs_pkg::LK_BOOT];
        rd[frs_pkg::LK_FUSE+1:frs_pkg::LK_FUSE] = boot_size_fuses;
      end
      frs_pkg::OFS_IRQ_STAT: rd[frs_pkg::EV_N-1:0] = s_ff.stat;
      frs_pkg::OFS_IRQ_EN:   rd[frs_pkg::EV_N-1:0] = s_ff.en;
      default: rd = frs_pkg::RD_ZERO;
    endcase
  end

  // bus handshake, register writes and irq status
  always_comb begin
    nxt_s         = s_ff;
    nxt_s.start   = 1'b0;
    nxt_s.clr_blk = 1'b0;
    // one wait cycle per access; data is latched in the same cycle
    nxt_s.wait_n  = (avs_read || avs_write) && !s_ff.wait_n;
    if ((avs_read || avs_write) && !s_ff.wait_n) nxt_s.rdata = rd;
    if (take && avs_write) begin
      unique case (avs_address)
        frs_pkg::OFS_PROG_CSR: begin
          // start ignored while busy so the latched page stays stable
          if (avs_writedata[frs_pkg::PC_START] && !sq.busy) begin
            nxt_s.start = 1'b1;
            nxt_s.erase = avs_writedata[frs_pkg::PC_ERASE];
            nxt_s.pc    = core_pc;
          end
          nxt_s.clr_blk = avs_writedata[frs_pkg::PC_CLR_BLK];
        end
        frs_pkg::OFS_PAGE: begin
          if (!sq.busy) nxt_s.page = avs_writedata[frs_pkg::PAGE_W-1:0];
        end
        frs_pkg::OFS_LOCK: begin
          // lock bits only set; clearing needs a reset, like a chip erase
          nxt_s.lock[frs_pkg::LK_APP]  = s_ff.lock[frs_pkg::LK_APP]
                                         | avs_writedata[frs_pkg::LK_APP];
          nxt_s.lock[frs_pkg::LK_BOOT] = s_ff.lock[frs_pkg::LK_BOOT]
                                         | avs_writedata[frs_pkg::LK_BOOT];
        end
        frs_pkg::OFS_IRQ_CLR:
          nxt_s.stat = s_ff.stat & ~avs_writedata[frs_pkg::EV_N-1:0];
        frs_pkg::OFS_IRQ_EN:
          nxt_s.en = avs_writedata[frs_pkg::EV_N-1:0];
        default: nxt_s.stat = s_ff.stat;
      endcase
    end
    // a new event beats a clear in the same cycle
    nxt_s.stat = nxt_s.stat | ev;
    nxt_s.irq  = |(s_ff.stat & s_ff.en);
    // vector base follows select and fuses
    nxt_s.vbase = vsel ? {frs_pkg::boot_first_page(boot_size_fuses),
                          {frs_pkg::WORD_W{1'b0}}}
                       : {frs_pkg::PC_W{1'b0}};
    nxt_s.halt    = sq.halt;
    nxt_s.blocked = sq.blocked;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) s_ff <= '0;
    else s_ff <= nxt_s;
  end

  // outputs, all registered
  assign avs_waitrequest    = !s_ff.wait_n;
  assign avs_readdata       = s_ff.rdata;
  assign vector_base        = s_ff.vbase;
  assign irq_block          = vblk;
  assign cpu_halt           = s_ff.halt;
  assign concurrent_blocked = s_ff.blocked;
  assign irq                = s_ff.irq;
endmodule
`default_nettype wire

// ---- src/frs_pkg.sv ----
// constants, field positions and types shared by the section control block
// assumes one clock domain, the processor core on the same clock as the flash
`default_nettype none
package frs_pkg;
  // program memory geometry, word addressed
  localparam int PC_W   = 14;
  localparam int PAGE_W = 8;
  localparam int WORD_W = 6;
  // first page of the stalling section; all boot sizes start at or above it
  localparam logic [PAGE_W-1:0] STALL_FIRST_PAGE = 8'he0;
  // relocation sequence timing in cycles
  localparam logic [2:0] UNLOCK_CYC    = 3'h4;
  localparam logic [1:0] AFTER_SEL_CYC = 2'h2;
  // register byte offsets
  localparam logic [4:0] OFS_CORE_CTL = 5'h00;
  localparam logic [4:0] OFS_PROG_CSR = 5'h04;
  localparam logic [4:0] OFS_PAGE     = 5'h08;
  localparam logic [4:0] OFS_LOCK     = 5'h0c;
  localparam logic [4:0] OFS_IRQ_STAT = 5'h10;
  localparam logic [4:0] OFS_IRQ_CLR  = 5'h14;
  localparam logic [4:0] OFS_IRQ_EN   = 5'h18;
  // core_control_reg fields
  localparam int CC_UNLOCK = 0;
  localparam int CC_SELECT = 1;
  // program_control_status_reg fields
  localparam int PC_START   = 0;
  localparam int PC_ERASE   = 1;
  localparam int PC_CLR_BLK = 4;
  localparam int PC_BLOCKED = 6;
  localparam int PC_BUSY    = 7;
  // lock register: one write-protect bit per section, fuses read at 9:8
  localparam int LK_APP  = 0;
  localparam int LK_BOOT = 1;
  localparam int LK_FUSE = 8;
  // interrupt events
  localparam int EV_DONE    = 0;
  localparam int EV_REFUSED = 1;
  localparam int EV_N       = 2;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  typedef enum logic {FRS_IDLE = 1'b0, FRS_RUN = 1'b1} frs_seq_st_t;

  // first boot page per fuse code, largest boot section at code zero
  function automatic logic [PAGE_W-1:0] boot_first_page(input logic [1:0] fuse);
    logic [PAGE_W-1:0] p;
    p = 8'he0;
    unique case (fuse)
      2'h0: p = 8'he0;
      2'h1: p = 8'hf0;
      2'h2: p = 8'hf8;
      2'h3: p = 8'hfc;
    endcase
    return p;
  endfunction
endpackage
`default_nettype wire

// ---- src/frs_seq_if.sv ----
// carrier between register front end and program sequencer
// assumes both ends on clk_sys
`default_nettype none
interface frs_seq_if;
  logic                        start;
  logic                        erase;
  logic [frs_pkg::PAGE_W-1:0]  page;
  logic [frs_pkg::PC_W-1:0]    pc;
  logic [1:0]                  lock;
  logic [1:0]                  fuse;
  logic                        clr_blk;
  logic                        busy;
  logic                        blocked;
  logic                        halt;
  logic                        done_ev;
  logic                        ref_ev;
  modport ctl (output start, erase, page, pc, lock, fuse, clr_blk,
               input busy, blocked, halt, done_ev, ref_ev);
  modport seq (input start, erase, page, pc, lock, fuse, clr_blk,
               output busy, blocked, halt, done_ev, ref_ev);
endinterface
`default_nettype wire

// ---- src/frs_vec_unlock.sv ----
// vector table select with timed unlock and interrupt blocking
// assumes wr is a one-cycle write strobe of core_control_reg
`default_nettype none
module frs_vec_unlock (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic reset,
  // register write
  input  wire logic wr,
  input  wire logic d_unlock,
  input  wire logic d_select,
  // state
  output logic      vector_change_unlock,
  output logic      vector_table_select,
  output logic      irq_block
);
  typedef struct packed {
    logic       unlock;
    logic       sel;
    logic       blk;
    logic [2:0] unl_cnt;
    logic [1:0] sel_cnt;
  } frs_vec_t;
  frs_vec_t s_ff, nxt_s;

  // countdowns first, a write then overrides them
  always_comb begin
    nxt_s = s_ff;
    if (s_ff.unl_cnt != 3'h0) nxt_s.unl_cnt = s_ff.unl_cnt - 3'h1;
    if (s_ff.unl_cnt == 3'h1) begin
      nxt_s.unlock = 1'b0;
      if (s_ff.sel_cnt == 2'h0) nxt_s.blk = 1'b0;
    end
    if (s_ff.sel_cnt != 2'h0) begin
      nxt_s.sel_cnt = s_ff.sel_cnt - 2'h1;
      if (s_ff.sel_cnt == 2'h1) nxt_s.blk = 1'b0;
    end
    if (wr) begin
      if (d_unlock) begin
        nxt_s.unlock  = 1'b1;
        nxt_s.unl_cnt = frs_pkg::UNLOCK_CYC;
        nxt_s.blk     = 1'b1;
        nxt_s.sel_cnt = 2'h0;
      end else if (s_ff.unlock) begin
        nxt_s.sel     = d_select;
        nxt_s.unlock  = 1'b0;
        nxt_s.unl_cnt = 3'h0;
        nxt_s.sel_cnt = frs_pkg::AFTER_SEL_CYC;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) s_ff <= '0;
    else s_ff <= nxt_s;
  end

  assign vector_change_unlock = s_ff.unlock;
  assign vector_table_select  = s_ff.sel;
  assign irq_block            = s_ff.blk;
endmodule
`default_nettype wire

// ---- src/frs_prog_seq.sv ----
// page erase/write sequencer: origin check, locks, section split, halt
// assumes flash_done is a one-cycle pulse from the flash macro on clk_sys
`default_nettype none
module frs_prog_seq (
  // clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       reset,
  // register side
  frs_seq_if.seq                          sq,
  // flash macro
  input  wire logic                       flash_done,
  output logic                            flash_req,
  output logic                            flash_erase,
  output logic [frs_pkg::PAGE_W-1:0]      flash_page
);
  typedef struct packed {
    frs_pkg::frs_seq_st_t        st;
    logic                        req;
    logic                        erase;
    logic [frs_pkg::PAGE_W-1:0]  page;
    logic                        blocked;
    logic                        halt;
    logic                        done_ev;
    logic                        ref_ev;
  } frs_seq_t;
  frs_seq_t s_ff, nxt_s;
  logic [frs_pkg::PAGE_W-1:0] boot_pg;
  logic                       from_boot;
  logic                       tgt_boot;
  logic                       locked;

  // boot start from fuses; always at or above the stalling boundary
  assign boot_pg   = frs_pkg::boot_first_page(sq.fuse);
  assign from_boot = sq.pc[frs_pkg::PC_W-1:frs_pkg::WORD_W] >= boot_pg;
  // any page may be targeted from boot, subject to its own section lock
  assign tgt_boot  = sq.page >= boot_pg;
  assign locked    = tgt_boot ? sq.lock[frs_pkg::LK_BOOT]
                              : sq.lock[frs_pkg::LK_APP];

  always_comb begin
    nxt_s         = s_ff;
    nxt_s.req     = 1'b0;
    nxt_s.done_ev = 1'b0;
    nxt_s.ref_ev  = 1'b0;
    // clear only when idle; an accepted start in the same cycle sets it again, a refused one leaves it clear
    if (sq.clr_blk && s_ff.st == frs_pkg::FRS_IDLE) nxt_s.blocked = 1'b0;
    unique case (s_ff.st)
      frs_pkg::FRS_IDLE: begin
        if (sq.start) begin
          if (!from_boot || locked) begin
            nxt_s.ref_ev = 1'b1;
          end else begin
            nxt_s.st      = frs_pkg::FRS_RUN;
            nxt_s.req     = 1'b1;
            nxt_s.erase   = sq.erase;
            nxt_s.page    = sq.page;
            nxt_s.blocked = 1'b1;
            nxt_s.halt    = sq.page >= frs_pkg::STALL_FIRST_PAGE;
          end
        end
      end
      frs_pkg::FRS_RUN: begin
        if (flash_done) begin
          nxt_s.st      = frs_pkg::FRS_IDLE;
          nxt_s.halt    = 1'b0;
          nxt_s.done_ev = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) s_ff <= '0;
    else s_ff <= nxt_s;
  end

  assign sq.busy     = s_ff.st == frs_pkg::FRS_RUN;
  assign sq.blocked  = s_ff.blocked;
  assign sq.halt     = s_ff.halt;
  assign sq.done_ev  = s_ff.done_ev;
  assign sq.ref_ev   = s_ff.ref_ev;
  assign flash_req   = s_ff.req;
  assign flash_erase = s_ff.erase;
  assign flash_page  = s_ff.page;
endmodule
`default_nettype wire

// ---- sim/frs_rww_ctl_properties.sv ----
// assertions on the section control top ports, bound into the top
// assumes one clk_sys domain and a synchronous active high reset
`default_nettype none
module frs_rww_ctl_properties (
  // clock and reset
  input wire logic                       clk_sys,
  input wire logic                       reset,
  // register bus
  input wire logic [4:0]                 avs_address,
  input wire logic                       avs_read,
  input wire logic                       avs_write,
  input wire logic [31:0]                avs_writedata,
  input wire logic                       avs_waitrequest,
  // core and flash
  input wire logic [frs_pkg::PC_W-1:0]   core_pc,
  input wire logic [1:0]                 boot_size_fuses,
  input wire logic [frs_pkg::PC_W-1:0]   vector_base,
  input wire logic                       irq_block,
  input wire logic                       cpu_halt,
  input wire logic                       concurrent_blocked,
  input wire logic                       flash_done,
  input wire logic                       flash_req,
  input wire logic [frs_pkg::PAGE_W-1:0] flash_page
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  logic [7:0] boot_pg;
  logic       clr_now;
  logic       clr_d_ff;
  logic       clr_d2_ff;
  // own boot start table, kept apart from the design's function
  always_comb begin
    case (boot_size_fuses)
      2'h0: boot_pg = 8'he0;
      2'h1: boot_pg = 8'hf0;
      2'h2: boot_pg = 8'hf8;
      default: boot_pg = 8'hfc;
    endcase
  end
  // a flag clear reaches the port two edges after the write, so remember both
  assign clr_now = avs_write && !avs_waitrequest && avs_address == frs_pkg::OFS_PROG_CSR
                   && avs_writedata[frs_pkg::PC_CLR_BLK];
  always_ff @(posedge clk_sys) clr_d_ff <= clr_now;
  always_ff @(posedge clk_sys) clr_d2_ff <= clr_d_ff;
  sequence s_wr(a);
    avs_write && !avs_waitrequest && avs_address == a;
  endsequence
  sequence s_unlock;
    s_wr(frs_pkg::OFS_CORE_CTL) ##0 avs_writedata[frs_pkg::CC_UNLOCK] && !irq_block;
  endsequence
  sequence s_start_app;
    s_wr(frs_pkg::OFS_PROG_CSR) ##0 avs_writedata[frs_pkg::PC_START] && core_pc[13:6] < boot_pg;
  endsequence
  a_bus_one_wait: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
    else $error("no answer one cycle after request");
  a_bus_taken_gap: assert property ((avs_read || avs_write) && !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low twice in a row");
  a_bus_idle_wait: assert property (!(avs_read || avs_write) |-> avs_waitrequest)
    else $error("waitrequest low while idle");
  a_unlock_window: assert property (s_unlock |=> irq_block[*2] ##[1:5] !irq_block)
    else $error("interrupt block window wrong");
  a_vector_cause: assert property ($changed(vector_base) |-> $past(irq_block))
    else $error("vector base moved outside relocation");
  a_vector_value: assert property (vector_base != '0 |-> vector_base == {boot_pg, 6'h00})
    else $error("vector base not at boot start");
  a_halt_section: assert property (flash_req |=>
    cpu_halt == ($past(flash_page) >= frs_pkg::STALL_FIRST_PAGE) && concurrent_blocked)
    else $error("halt or blocked flag wrong at start");
  a_halt_holds: assert property (cpu_halt && !flash_done && !$past(flash_done) |=> cpu_halt)
    else $error("halt released before done");
  a_flag_sticky: assert property (concurrent_blocked && !clr_now && !clr_d_ff
    && !clr_d2_ff |=> concurrent_blocked)
    else $error("blocked flag released by itself");
  a_app_refused: assert property (s_start_app |-> ##2 !flash_req)
    else $error("start from application section ran");
  a_req_pulse: assert property (flash_req |=> !flash_req)
    else $error("flash request longer than one cycle");
endmodule
bind frs_rww_ctl frs_rww_ctl_properties frs_rww_ctl_properties_i (
  .clk_sys(clk_sys), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
  .core_pc(core_pc), .boot_size_fuses(boot_size_fuses), .vector_base(vector_base),
  .irq_block(irq_block), .cpu_halt(cpu_halt), .concurrent_blocked(concurrent_blocked),
  .flash_done(flash_done), .flash_req(flash_req), .flash_page(flash_page));
`default_nettype wire

// ---- sim/frs_core_model.sv ----
// far side model: flash macro timing and the core that stalls on halt
// assumes flash_req is a one-cycle pulse on clk_sys
`default_nettype none
module frs_core_model (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset,
  // flash macro
  input  wire logic       flash_req,
  input  wire logic [7:0] done_dly,
  output logic            flash_done,
  // core
  input  wire logic       cpu_halt,
  output logic [7:0]      stall_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_ff;
  logic       run_ff;
  // done pulse comes done_dly+2 cycles after the request, slow or prompt
  always_ff @(posedge clk_sys) begin
    flash_done <= 1'b0;
    if (reset) begin
      run_ff <= 1'b0;
      cnt_ff <= 8'h00;
    end else if (flash_req) begin
      run_ff <= 1'b1;
      cnt_ff <= done_dly;
    end else if (run_ff && cnt_ff == 8'h00) begin
      run_ff     <= 1'b0;
      flash_done <= 1'b1;
    end else if (run_ff) begin
      cnt_ff <= cnt_ff - 8'h01;
    end
  end
  // core fetches nothing while halted; count those cycles
  always_ff @(posedge clk_sys) begin
    if (reset || flash_req) stall_cnt <= 8'h00;
    else if (cpu_halt) stall_cnt <= stall_cnt + 8'h01;
  end
endmodule
`default_nettype wire

// ---- sim/test_flash_rww_section_control.sv ----
// self-checking bench for the program memory section control
// assumes the far side model beside the top and one 40 MHz clock
`default_nettype none
module test_flash_rww_section_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic                      clk_sys = 1'b0;
  logic                      reset = 1'b1;
  logic [4:0]                avs_address = 5'h00;
  logic                      avs_read = 1'b0;
  logic                      avs_write = 1'b0;
  logic [31:0]               avs_writedata = 32'h0000_0000;
  logic [31:0]               avs_readdata;
  logic                      avs_waitrequest;
  logic [frs_pkg::PC_W-1:0]  core_pc = 14'h0000;
  logic [1:0]                boot_size_fuses = 2'h0;
  logic [frs_pkg::PC_W-1:0]  vector_base;
  logic                      irq_block, cpu_halt, concurrent_blocked, flash_done;
  logic                      flash_req, flash_erase, irq;
  logic [7:0]                flash_page, stall_cnt, bfp;
  logic [7:0]                done_dly = 8'h01;
  logic [31:0]               rng = 32'h7b95_1bcc;
  logic [31:0]               exp_q[$];
  int                        bad_count = 0;
  int                        n_checks = 0;
  always #12.5 clk_sys = ~clk_sys;
  frs_rww_ctl frs_rww_ctl_i (.clk_sys(clk_sys), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .core_pc(core_pc),
    .boot_size_fuses(boot_size_fuses), .vector_base(vector_base), .irq_block(irq_block),
    .cpu_halt(cpu_halt), .concurrent_blocked(concurrent_blocked), .flash_done(flash_done),
    .flash_req(flash_req), .flash_erase(flash_erase), .flash_page(flash_page), .irq(irq));
  frs_core_model frs_core_model_i (.clk_sys(clk_sys), .reset(reset), .flash_req(flash_req),
    .done_dly(done_dly), .flash_done(flash_done), .cpu_halt(cpu_halt), .stall_cnt(stall_cnt));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic hung(input string m);
    bad_count++;
    $display("wrong value at %0t: %s timed out", $time, m);
    end_of_test();
  endtask
  // one bus access; for a read d is the expected word, noted for the monitor
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address   <= a;
    avs_writedata <= d;
    if (wr) avs_write <= 1'b1;
    else avs_read <= 1'b1;
    if (!wr) exp_q.push_back(d);
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) hung("bus");
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge clk_sys);
  endtask
  // bounded wait for flash_req (0) or irq (1)
  task automatic wait_hi(input int sel, input string m);
    int n;
    n = 0;
    while ((sel == 0 ? flash_req : irq) !== 1'b1 && n < 400) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 400) hung(m);
  endtask
  // read monitor: oldest note against the word taken at this edge
  always @(posedge clk_sys) begin
    if (avs_read && avs_waitrequest === 1'b0) begin
      if (exp_q.size() == 0) hung("scoreboard");
      else chk(avs_readdata, exp_q.pop_front(), "read data");
    end
  end
  // one erase or write; ok low means it must be refused, irq masked meanwhile
  task automatic prog(input logic [7:0] pg, input logic [13:0] pc, input logic er,
                      input logic ok);
    core_pc <= pc;
    bus(1'b1, frs_pkg::OFS_IRQ_EN, {30'h0, ok, ok});
    bus(1'b1, frs_pkg::OFS_PAGE, {24'h0, pg});
    bus(1'b1, frs_pkg::OFS_PROG_CSR, {30'h0, er, 1'b1});
    if (ok) begin
      wait_hi(0, "request");
      @(posedge clk_sys);
      chk(32'(cpu_halt), 32'(pg >= frs_pkg::STALL_FIRST_PAGE), "halt");
      chk(32'(concurrent_blocked), 32'h1, "blocked at start");
      chk(32'(flash_erase), 32'(er), "erase kind");
      chk(32'(flash_page), 32'(pg), "target page");
      // busy, blocked and erase read back while the operation still runs
      bus(1'b0, frs_pkg::OFS_PROG_CSR, {24'h0, 2'b11, 4'h0, er, 1'b0});
      wait_hi(1, "done irq");
      chk(32'(stall_cnt >= done_dly), 32'(pg >= frs_pkg::STALL_FIRST_PAGE), "stall");
      bus(1'b0, frs_pkg::OFS_IRQ_STAT, 32'h0000_0001);
    end else begin
      repeat (4) @(posedge clk_sys);
      chk(32'(irq), 32'h0, "masked irq");
      bus(1'b1, frs_pkg::OFS_IRQ_EN, 32'h0000_0003);
      wait_hi(1, "refused irq");
      bus(1'b0, frs_pkg::OFS_IRQ_STAT, 32'h0000_0002);
    end
    bus(1'b1, frs_pkg::OFS_IRQ_CLR, 32'h0000_0003);
    @(posedge clk_sys);
    chk(32'(irq), 32'h0, "irq cleared");
    chk(32'(concurrent_blocked), 32'(ok), "flag held");
    bus(1'b1, frs_pkg::OFS_PROG_CSR, 32'h0000_0010);
    // the clear passes the sequencer and the output flop: two edges
    repeat (2) @(posedge clk_sys);
    chk(32'(concurrent_blocked), 32'h0, "flag cleared");
  endtask
  // watchdog so that no hang goes unreported
  initial begin
    repeat (20000) @(posedge clk_sys);
    hung("run");
  end
  // main sequence
  initial begin
    @(posedge clk_sys);
    rng = xs(rng);
    boot_size_fuses <= rng[1:0];
    repeat (15) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    case (boot_size_fuses)
      2'h0: bfp = 8'he0;
      2'h1: bfp = 8'hf0;
      2'h2: bfp = 8'hf8;
      default: bfp = 8'hfc;
    endcase
    for (int a = 0; a < 32; a += 4) begin
      bus(1'b0, 5'(a), a == 12 ? {22'h0, boot_size_fuses, 8'h00} : 32'h0000_0000);
    end
    chk(32'(vector_base), 32'h0, "vector after reset");
    $display("test reset values done");
    bus(1'b1, frs_pkg::OFS_CORE_CTL, 32'h0000_0002);
    bus(1'b0, frs_pkg::OFS_CORE_CTL, 32'h0000_0000);
    for (int v = 1; v >= 0; v--) begin
      bus(1'b1, frs_pkg::OFS_CORE_CTL, 32'h0000_0001);
      chk(32'(irq_block), 32'h1, "block on unlock");
      bus(1'b1, frs_pkg::OFS_CORE_CTL, {30'h0, 1'(v), 1'b0});
      bus(1'b0, frs_pkg::OFS_CORE_CTL, {30'h0, 1'(v), 1'b0});
      chk(32'(vector_base), v == 1 ? {18'h0, bfp, 6'h00} : 32'h0, "vector");
    end
    bus(1'b1, frs_pkg::OFS_CORE_CTL, 32'h0000_0003);
    repeat (6) @(posedge clk_sys);
    chk(32'(irq_block), 32'h0, "block expired");
    bus(1'b1, frs_pkg::OFS_CORE_CTL, 32'h0000_0002);
    bus(1'b0, frs_pkg::OFS_CORE_CTL, 32'h0000_0000);
    $display("test relocation done");
    rng = xs(rng);
    done_dly <= 8'h14 + {2'h0, rng[5:0]};
    prog(bfp, {8'hff, 6'h00}, 1'b1, 1'b1);
    $display("test stalling page done");
    bus(1'b1, frs_pkg::OFS_LOCK, 32'h0000_0002);
    done_dly <= 8'h01;
    rng = xs(rng);
    prog(8'(rng[15:0] % 16'h00e0), {8'hff, 6'h00}, 1'b0, 1'b1);
    prog(bfp, {8'hff, 6'h00}, 1'b0, 1'b0);
    prog(8'h10, 14'h0040, 1'b1, 1'b0);
    $display("test sections and locks done");
    end_of_test();
  end
endmodule
`default_nettype wire
